// *** rtl/pfa_defines.vh ***
// Constants for the PCM frame alignment receiver
`ifndef PFA_DEFINES_VH
`define PFA_DEFINES_VH

// APB register byte offsets
`define PFA_OFS_CTRL        8'h00
`define PFA_OFS_STATUS      8'h04
`define PFA_OFS_INT_STAT    8'h08
`define PFA_OFS_INT_EN      8'h0C
`define PFA_OFS_INT_CLR     8'h10
`define PFA_OFS_RX_BITS     8'h14

// Reset values
`define PFA_CTRL_RST        1'h1
`define PFA_INT_EN_RST      3'h0

// Interrupt bit positions (status, enable and clear share them)
`define PFA_INT_LOSS        0
`define PFA_INT_REGAIN      1
`define PFA_INT_WORD_ERR    2
`define PFA_INT_W           3

// Frame geometry: 32 slots of 8 bits, bit index 0..255
`define PFA_BIT_LAST        8'hFF
`define PFA_TS0_LAST        8'h07
`define PFA_EVAL_BIT        8'h08

// Sync word bits 2..8 and the fixed non-sync bit 2
`define PFA_SYNC_PATTERN    7'h1B
`define PFA_NSF_BIT2        1'h1

// Consecutive counts for loss and regain
`define PFA_LOSS_COUNT      2'h3
`define PFA_REGAIN_COUNT    2'h3

// Framer states
`define PFA_ST_SEARCH       2'h0
`define PFA_ST_VERIFY       2'h1
`define PFA_ST_LOCK         2'h2

`endif

// *** rtl/pfa_frame_align.v ***
// Receive frame alignment for a 2.048 Mbit/s 30+2 channel PCM link
//
// What this block does
// (R1) Line data enters one bit per strobe through the shift register into the detector.
// (R2) The line bit rate is 2.048 MHz, one strobe per bit.
// (R3) Three consecutive errored sync words declare loss of frame synchronism.
// (R4) Slot zero pulse high 8 bit periods from end of sync word bit 1.
// (R5) Channel reset low first bit after slot zero of sync frames, in sync only.
// (R6) Sync-frame bit one output takes bit 1 of slot zero.
// (R7) Non-sync bit one and spare bits 3..8 come from non-sync slot zero.
// (R8) Bit outputs update at the start of slot one and hold otherwise.
// (R9) An errored sync word raises error at slot zero end two sync frames later.
// (R10) Error stays high while sync words keep arriving errored.
// (R11) After a sync alarm the error output stays high until sync regained.
// (R12) Sync alarm rises at slot zero pulse end of third errored sync frame.
// (R13) Sync alarm falls at pulse end of third consecutive good frame.
// (R14) The sync word is expected only in slot zero of alternate frames.
// (R15) Sync word bits 2..8 are 0011011; non-sync bit 2 is one.
// (R16) A frame is 32 slots of 8 bits, slot zero first.
// (R17) Out of sync, every bit position is tested; first match adopts alignment.
// (R18) After reset: out of sync, alarm high, channel reset pulses suppressed.
`timescale 1ns/1ps
`default_nettype none
`include "pfa_defines.vh"

module pfa_frame_align (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        line_data,
    input  wire        line_bit_en,
    output reg         time_slot_zero_pulse,
    output reg         channel_reset_pulse_n,
    output reg         sync_alarm,
    output reg         sync_word_error,
    output reg         frame_bit_one_out,
    output reg         nsync_bit_one_out,
    output reg  [5:0]  spare_bits_out,
    output wire        irq
);

    // Framer state
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [7:0]  bit_cnt_reg;
    reg  [7:0]  bit_cnt_next;
    reg         sync_frm_reg;
    reg         sync_frm_next;
    reg  [1:0]  bad_run_reg;
    reg  [1:0]  bad_run_next;
    reg  [1:0]  good_run_reg;
    reg  [1:0]  good_run_next;
    reg  [1:0]  err_hist_reg;
    reg  [1:0]  err_hist_next;
    reg         alarm_next;
    reg         error_next;
    reg         ev_loss;
    reg         ev_regain;
    reg         ev_word_err;

    // Register file
    reg         ctrl_en_reg;
    reg  [`PFA_INT_W-1:0] int_stat_reg;
    reg  [`PFA_INT_W-1:0] int_en_reg;
    wire [`PFA_INT_W-1:0] int_set;
    wire [`PFA_INT_W-1:0] int_clr;

    // Detector outputs
    wire [7:0]  word_reg;
    wire [7:0]  word_next;
    wire        match_next;
    wire        match_cur;
    wire        nsf_ok_cur;

    wire        aligned;
    wire        at_eval;
    wire        frame_good;
    wire        wr_en;
    wire        rd_en;
    reg         addr_hit;

    // Shift register and sync word detector
    pfa_serial_in_shift_register_det u_serial_in_shift_register (
        .pclk       (pclk),
        .presetn    (presetn),
        .shift_en   (line_bit_en),  // see (R1)
        .din        (line_data),
        .word_reg   (word_reg),
        .word_next  (word_next),
        .match_next (match_next),
        .match_cur  (match_cur),
        .nsf_ok_cur (nsf_ok_cur)
    );

    // Frame alignment held in verify and lock
    assign aligned = (state_reg != `PFA_ST_SEARCH);
    // Strobe opening slot one: word_reg then holds all of slot zero
    assign at_eval = line_bit_en && aligned && (bit_cnt_reg == `PFA_EVAL_BIT);
    // Sync frames need the word, others bit 2 set
    assign frame_good = sync_frm_reg ? match_cur : nsf_ok_cur;  // see (R14) (R15)

    // Framer next state, one step per line bit strobe
    always @* begin
        state_next    = state_reg;
        bit_cnt_next  = bit_cnt_reg;
        sync_frm_next = sync_frm_reg;
        bad_run_next  = bad_run_reg;
        good_run_next = good_run_reg;
        err_hist_next = err_hist_reg;
        alarm_next    = sync_alarm;
        error_next    = sync_word_error;
        ev_loss       = 1'b0;
        ev_regain     = 1'b0;
        ev_word_err   = 1'b0;
        if (!ctrl_en_reg) begin
            state_next    = `PFA_ST_SEARCH;
            bit_cnt_next  = 8'h00;
            bad_run_next  = 2'h0;
            good_run_next = 2'h0;
            err_hist_next = 2'h0;
            alarm_next    = 1'b1;
            error_next    = 1'b1;
        end else if (line_bit_en) begin
            // Free-running bit index, wraps after 32 slots
            if (bit_cnt_reg == `PFA_BIT_LAST) begin
                bit_cnt_next  = 8'h00;  // see (R16)
                sync_frm_next = ~sync_frm_reg;  // see (R14)
            end else begin
                bit_cnt_next = bit_cnt_reg + 8'h01;
            end
            case (state_reg)
                `PFA_ST_SEARCH: begin
                    // Test every bit position, adopt at first match
                    if (match_next) begin  // see (R17)
                        state_next    = `PFA_ST_VERIFY;
                        bit_cnt_next  = `PFA_EVAL_BIT;
                        sync_frm_next = 1'b1;
                        good_run_next = 2'h0;
                    end
                end
                `PFA_ST_VERIFY: begin
                    if (at_eval) begin
                        if (frame_good) begin
                            good_run_next = good_run_reg + 2'h1;
                            if (good_run_reg + 2'h1 == `PFA_REGAIN_COUNT) begin
                                // Third good frame in a row
                                state_next    = `PFA_ST_LOCK;
                                alarm_next    = 1'b0;  // see (R13)
                                error_next    = 1'b0;  // see (R11)
                                bad_run_next  = 2'h0;
                                err_hist_next = 2'h0;
                                ev_regain     = 1'b1;
                            end
                        end else begin
                            // False alignment, search again
                            state_next    = `PFA_ST_SEARCH;
                            good_run_next = 2'h0;
                        end
                    end
                end
                `PFA_ST_LOCK: begin
                    if (at_eval && sync_frm_reg) begin
                        // Errored word reported two sync frames later
                        err_hist_next = {err_hist_reg[0], ~match_cur};
                        error_next    = err_hist_reg[1];  // see (R9) (R10)
                        ev_word_err   = ~match_cur;
                        if (!match_cur) begin
                            bad_run_next = bad_run_reg + 2'h1;
                            if (bad_run_reg + 2'h1 == `PFA_LOSS_COUNT) begin
                                // Third errored word in a row
                                state_next    = `PFA_ST_SEARCH;  // see (R3)
                                alarm_next    = 1'b1;  // see (R12)
                                error_next    = 1'b1;  // see (R11)
                                bad_run_next  = 2'h0;
                                good_run_next = 2'h0;
                                ev_loss       = 1'b1;
                            end
                        end else begin
                            bad_run_next = 2'h0;
                        end
                    end
                end
                default: begin
                    state_next = `PFA_ST_SEARCH;
                end
            endcase
        end
    end

    // Framer registers; out of sync with alarm and error high at reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg       <= `PFA_ST_SEARCH;  // see (R18)
            bit_cnt_reg     <= 8'h00;
            sync_frm_reg    <= 1'b0;
            bad_run_reg     <= 2'h0;
            good_run_reg    <= 2'h0;
            err_hist_reg    <= 2'h0;
            sync_alarm      <= 1'b1;  // see (R18)
            sync_word_error <= 1'b1;
        end else begin
            state_reg       <= state_next;
            bit_cnt_reg     <= bit_cnt_next;
            sync_frm_reg    <= sync_frm_next;
            bad_run_reg     <= bad_run_next;
            good_run_reg    <= good_run_next;
            err_hist_reg    <= err_hist_next;
            sync_alarm      <= alarm_next;
            sync_word_error <= error_next;
        end
    end

    // Slot zero pulse and channel reset, one bit period granularity
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_slot_zero_pulse  <= 1'b0;
            channel_reset_pulse_n <= 1'b1;  // see (R18)
        end else if (!ctrl_en_reg) begin
            time_slot_zero_pulse  <= 1'b0;
            channel_reset_pulse_n <= 1'b1;
        end else if (line_bit_en) begin
            // High for 8 bit periods, from end of bit 1 through end of bit 9
            time_slot_zero_pulse  <= aligned && (bit_cnt_reg <= `PFA_TS0_LAST);  // see (R4)
            // Low for the first bit after slot zero of sync frames
            channel_reset_pulse_n <= ~(state_reg == `PFA_ST_LOCK && sync_frm_reg
                                       && bit_cnt_reg == `PFA_EVAL_BIT);  // see (R5)
        end
    end

    // Spare bits of slot zero, latched at the opening of slot one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_bit_one_out <= 1'b0;
            nsync_bit_one_out <= 1'b0;
            spare_bits_out    <= 6'h00;
        end else if (at_eval) begin  // see (R8)
            if (sync_frm_reg) begin
                frame_bit_one_out <= word_reg[7];  // see (R6)
            end else begin
                nsync_bit_one_out <= word_reg[7];  // see (R7)
                spare_bits_out    <= word_reg[5:0];  // see (R7)
            end
        end
    end

    // APB: zero wait states, error on unmapped offsets
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !pwrite;
    assign pslverr = psel && penable && !addr_hit;

    // Address decode and read mux
    always @* begin
        addr_hit = 1'b1;
        case (paddr)
            `PFA_OFS_CTRL:     prdata = {31'h0000_0000, ctrl_en_reg};
            `PFA_OFS_STATUS:   prdata = {16'h0000, bit_cnt_reg, 2'h0, state_reg,
                                         sync_frm_reg, sync_word_error, sync_alarm,
                                         time_slot_zero_pulse};
            `PFA_OFS_INT_STAT: prdata = {29'h0000_0000, int_stat_reg};
            `PFA_OFS_INT_EN:   prdata = {29'h0000_0000, int_en_reg};
            `PFA_OFS_INT_CLR:  prdata = 32'h0000_0000;
            `PFA_OFS_RX_BITS:  prdata = {24'h00_0000, frame_bit_one_out,
                                         nsync_bit_one_out, spare_bits_out};
            default: begin
                prdata   = 32'h0000_0000;
                addr_hit = 1'b0;
            end
        endcase
        if (!rd_en) begin
            prdata = 32'h0000_0000;
        end
    end

    // Writable registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_reg <= `PFA_CTRL_RST;
            int_en_reg  <= `PFA_INT_EN_RST;
        end else if (wr_en) begin
            if (paddr == `PFA_OFS_CTRL) begin
                ctrl_en_reg <= pwdata[0];
            end
            if (paddr == `PFA_OFS_INT_EN) begin
                int_en_reg <= pwdata[`PFA_INT_W-1:0];
            end
        end
    end

    // Sticky interrupt status; a new event wins over a clear
    assign int_set[`PFA_INT_LOSS]     = ev_loss;
    assign int_set[`PFA_INT_REGAIN]   = ev_regain;
    assign int_set[`PFA_INT_WORD_ERR] = ev_word_err;
    assign int_clr = (wr_en && paddr == `PFA_OFS_INT_CLR) ? pwdata[`PFA_INT_W-1:0]
                                                          : {`PFA_INT_W{1'b0}};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= {`PFA_INT_W{1'b0}};
        end else begin
            int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
        end
    end

    // Level interrupt while any enabled status bit is set
    assign irq = |(int_stat_reg & int_en_reg);

endmodule // pfa_frame_align

`default_nettype wire

// *** rtl/pfa_serial_in_shift_register_det.v ***
// Serial-in shift register with sync word detector
`timescale 1ns/1ps
`default_nettype none
`include "pfa_defines.vh"

module pfa_serial_in_shift_register_det (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       shift_en,
    input  wire       din,
    output reg  [7:0] word_reg,
    output wire [7:0] word_next,
    output wire       match_next,
    output wire       match_cur,
    output wire       nsf_ok_cur
);

    // Bits 2..8 of a slot against the sync pattern; bit 1 is free
    function sync_hit;
        input [7:0] w;
        begin
            sync_hit = (w[6:0] == `PFA_SYNC_PATTERN);
        end
    endfunction

    // Oldest bit (slot bit 1) sits in bit 7
    assign word_next  = shift_en ? {word_reg[6:0], din} : word_reg;
    assign match_next = sync_hit({word_reg[6:0], din});
    assign match_cur  = sync_hit(word_reg);
    assign nsf_ok_cur = (word_reg[6] == `PFA_NSF_BIT2);

    // Shift one line bit per strobe
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_reg <= 8'h00;
        end else begin
            word_reg <= word_next;
        end
    end

endmodule // pfa_serial_in_shift_register_det

`default_nettype wire

// *** test/pfa_frame_align_properties.sv ***
// Concurrent checks on the frame alignment receiver ports
`timescale 1ns/1ps
`default_nettype none
module pfa_frame_align_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pslverr,
    input wire logic        line_bit_en,
    input wire logic        time_slot_zero_pulse,
    input wire logic        channel_reset_pulse_n,
    input wire logic        sync_alarm,
    input wire logic        sync_word_error,
    input wire logic        frame_bit_one_out,
    input wire logic        nsync_bit_one_out,
    input wire logic [5:0]  spare_bits_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] hi_cnt_reg;
    // Strobes counted while the slot zero pulse is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hi_cnt_reg <= 4'h0;
        else if (!time_slot_zero_pulse) hi_cnt_reg <= 4'h0;
        else if (line_bit_en) hi_cnt_reg <= hi_cnt_reg + 4'h1;
    end
    chk_pulse_eight: assert property ($fell(time_slot_zero_pulse) |-> hi_cnt_reg == 4'h8)
        else $error("slot zero pulse not eight bit periods");
    chk_chres_end: assert property ($fell(channel_reset_pulse_n) |->
        $fell(time_slot_zero_pulse) && !(sync_alarm && $past(sync_alarm)))
        else $error("channel reset outside sync frame end");
    chk_chres_one: assert property (!channel_reset_pulse_n && line_bit_en |=> channel_reset_pulse_n)
        else $error("channel reset longer than one bit");
    chk_alarm_edge: assert property (!$stable(sync_alarm) |-> $fell(time_slot_zero_pulse))
        else $error("sync alarm moved away from pulse end");
    chk_err_edge: assert property (!$stable(sync_word_error) |-> $fell(time_slot_zero_pulse))
        else $error("error output moved away from pulse end");
    chk_alarm_err: assert property (sync_alarm |-> sync_word_error)
        else $error("error low while alarm high");
    chk_out_strobe: assert property (!$stable({time_slot_zero_pulse, frame_bit_one_out, nsync_bit_one_out,
        spare_bits_out}) |-> $past(line_bit_en))
        else $error("output changed without a line strobe");
    chk_slverr_map: assert property (psel && penable |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0))
        else $error("slave error does not match address map");
endmodule // pfa_frame_align_properties
bind pfa_frame_align pfa_frame_align_properties chk_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pslverr(pslverr), .line_bit_en(line_bit_en),
    .time_slot_zero_pulse(time_slot_zero_pulse), .channel_reset_pulse_n(channel_reset_pulse_n),
    .sync_alarm(sync_alarm), .sync_word_error(sync_word_error), .frame_bit_one_out(frame_bit_one_out),
    .nsync_bit_one_out(nsync_bit_one_out), .spare_bits_out(spare_bits_out));
`default_nettype wire

// *** test/pfa_line_src.sv ***
// Upstream line decoder model sending framed serial line data
`timescale 1ns/1ps
`default_nettype none
`include "pfa_defines.vh"
module pfa_line_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] gap,
    input  wire logic       corrupt,
    input  wire logic       sf_bit1,
    input  wire logic       nsf_bit1,
    input  wire logic [5:0] spare,
    output logic            line_data,
    output logic            line_bit_en,
    output logic [7:0]      cur_idx
);
    logic [2:0] wait_reg;
    logic [7:0] pos_reg;
    logic       sf_reg;
    logic [6:0] pat;
    logic [2:0] k;
    logic       bit_val;
    assign pat = `PFA_SYNC_PATTERN;
    assign k = pos_reg[2:0];
    // Slot zero carries sync word or spare bits, other slots idle at one
    always_comb begin
        if (pos_reg[7:3] != 5'h00) bit_val = 1'b1;
        else if (sf_reg) bit_val = (k == 3'h0) ? sf_bit1 : pat[3'h7 - k] ^ (corrupt && k == 3'h7);
        else if (k == 3'h0) bit_val = nsf_bit1;
        else if (k == 3'h1) bit_val = `PFA_NSF_BIT2;
        else bit_val = spare[3'h7 - k];
    end
    // One strobe per gap cycles, idle line toggles every cycle between strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 3'h0;
            pos_reg <= 8'h00;
            sf_reg <= 1'b1;
            line_data <= 1'b0;
            line_bit_en <= 1'b0;
            cur_idx <= 8'h00;
        end else if (wait_reg + 3'h1 >= gap) begin
            wait_reg <= 3'h0;
            line_bit_en <= 1'b1;
            line_data <= bit_val;
            cur_idx <= pos_reg;
            pos_reg <= pos_reg + 8'h01;
            if (pos_reg == 8'hFF) sf_reg <= ~sf_reg;
        end else begin
            wait_reg <= wait_reg + 3'h1;
            line_bit_en <= 1'b0;
            line_data <= ~line_data;
        end
    end
endmodule // pfa_line_src
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the PCM frame alignment receiver
`timescale 1ns/1ps
`default_nettype none
`include "pfa_defines.vh"
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata;
    logic        pready, pslverr, rerr, irq, line_data, line_bit_en;
    logic        tsz, chres_n, alarm, err, f1, n1;
    logic [5:0]  sp;
    logic [7:0]  cur_idx;
    logic [2:0]  gap = 3'h4;
    logic        corrupt = 1'b0, sf1_in = 1'b0, nsf1_in = 1'b1, ef1 = 1'b0, en1 = 1'b0, errv = 1'b0;
    logic [5:0]  spare_in = 6'h10, esp = 6'h00;
    logic [15:0] rnd = 16'h0029;
    int          n_errors = 0, samples_checked = 0;
    always #5 pclk = ~pclk;
    pfa_frame_align dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_data(line_data), .line_bit_en(line_bit_en), .time_slot_zero_pulse(tsz),
        .channel_reset_pulse_n(chres_n), .sync_alarm(alarm), .sync_word_error(err), .frame_bit_one_out(f1),
        .nsync_bit_one_out(n1), .spare_bits_out(sp), .irq(irq));
    pfa_line_src src_u (.pclk(pclk), .presetn(presetn), .gap(gap), .corrupt(corrupt), .sf_bit1(sf1_in),
        .nsf_bit1(nsf1_in), .spare(spare_in), .line_data(line_data), .line_bit_en(line_bit_en),
        .cur_idx(cur_idx));
    // Expected alarm per evaluated frame and corrupted sync frames
    function automatic logic alarm_exp(input int e);
        return e < 2 || (e >= 28 && e < 32);
    endfunction
    function automatic logic bad(input int s);
        return s == 3 || s == 7 || s == 8 || (s >= 12 && s <= 14);
    endfunction
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic final_report;
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog against a hung run
    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        final_report;
    end
    // Main sequence: reset, lock, word errors, loss and regain
    initial begin
        repeat (10) @(posedge pclk);
        check(32'({alarm, err, chres_n, tsz}), 32'hE);
        presetn <= 1'b1;
        for (int e = 0; e < 36; e++) begin
            // Slot zero pulse already high at the bit 8 strobe while aligned
            do @(posedge pclk); while (!(line_bit_en === 1'b1 && cur_idx == 8'h07));
            #1;
            check(32'(tsz), 32'(e != 0 && e != 29 && e != 30));
            do @(posedge pclk); while (!(line_bit_en === 1'b1 && cur_idx == 8'h08));
            #1;
            if (e % 2 == 0 && !alarm_exp(e)) errv = bad(e / 2 - 2) && !alarm_exp(e - 4);
            check(32'({alarm, err}), 32'({alarm_exp(e), alarm_exp(e) | errv}));
            check(32'(tsz), 32'h0);
            if (alarm_exp(e) == alarm_exp(e - 1))
                check(32'(chres_n), 32'(!(e % 2 == 0 && !alarm_exp(e))));
            if (e % 2 == 0) ef1 = sf1_in;
            else begin
                en1 = nsf1_in;
                esp = spare_in;
            end
            if (!alarm_exp(e) && !alarm_exp(e - 1))
                check(32'({f1, n1, sp}), 32'({ef1, en1, esp}));
            @(posedge pclk);
            rnd = lfsr(rnd);
            sf1_in <= rnd[0];
            nsf1_in <= rnd[1];
            spare_in <= rnd[7:2] | 6'h10;
            gap <= 3'(rnd[9:8]) + 3'h1;
            corrupt <= bad((e + 1) / 2) && (e % 2 == 1);
            if (e == 0) begin
                apb(1'b0, `PFA_OFS_CTRL, 32'h0);
                check(rdata, 32'h1);
                apb(1'b0, `PFA_OFS_INT_EN, 32'h0);
                check(rdata, 32'h0);
                apb(1'b0, `PFA_OFS_STATUS, 32'h0);
                check(rdata & 32'h6, 32'h6);
                apb(1'b0, `PFA_OFS_INT_CLR, 32'h0);
                check(rdata, 32'h0);
                apb(1'b1, 8'h18, 32'hFFFF);
                check(32'(rerr), 32'h1);
                apb(1'b0, 8'h18, 32'h0);
                check(rdata, 32'h0);
            end
            if (e == 3) begin
                apb(1'b0, `PFA_OFS_INT_STAT, 32'h0);
                check(rdata, 32'h2);
                check(32'(irq), 32'h0);
                apb(1'b1, `PFA_OFS_INT_EN, 32'h2);
                #1 check(32'(irq), 32'h1);
                apb(1'b1, `PFA_OFS_INT_CLR, 32'h2);
                #1 check(32'(irq), 32'h0);
                apb(1'b1, `PFA_OFS_INT_EN, 32'h7);
                apb(1'b0, `PFA_OFS_INT_EN, 32'h0);
                check(rdata, 32'h7);
            end
            // Framer held in search while disabled, released again before the next sync word
            if (e == 29) begin
                apb(1'b1, `PFA_OFS_CTRL, 32'h0);
                apb(1'b0, `PFA_OFS_STATUS, 32'h0);
                check(rdata & 32'hFF37, 32'h6);
                apb(1'b1, `PFA_OFS_CTRL, 32'h1);
            end
        end
        apb(1'b0, `PFA_OFS_INT_STAT, 32'h0);
        check(rdata, 32'h7);
        check(32'(irq), 32'h1);
        apb(1'b0, `PFA_OFS_RX_BITS, 32'h0);
        check(rdata, 32'({ef1, en1, esp}));
        final_report;
    end
endmodule // tb
`default_nettype wire
